// file: src/cag_pkg.sv
package cag_pkg;

    // ======================================================================
    // operation requests from the sequencer
    typedef enum logic [3:0] {
        CAG_OP_REL    = 4'h0,
        CAG_OP_JMP16  = 4'h1,
        CAG_OP_FIXED  = 4'h2,
        CAG_OP_VEC    = 4'h3,
        CAG_OP_REGJ   = 4'h4,
        CAG_OP_MUL    = 4'h5,
        CAG_OP_DIV    = 4'h6,
        CAG_OP_IMPL   = 4'h7,
        CAG_OP_REGB   = 4'h8,
        CAG_OP_REGW   = 4'h9,
        CAG_OP_DIR    = 4'hA,
        CAG_OP_SADDR  = 4'hB,
        CAG_OP_SADDRP = 4'hC,
        CAG_OP_SFR    = 4'hD,
        CAG_OP_SFRP   = 4'hE
    } cag_op_t;

    typedef enum logic [1:0] {
        CAG_AREA_NONE = 2'h0,
        CAG_AREA_RAM  = 2'h1,
        CAG_AREA_SFR  = 2'h2,
        CAG_AREA_MEM  = 2'h3
    } cag_area_t;

    typedef enum logic [3:0] {
        CAG_ST_IDLE = 4'b0001,
        CAG_ST_ACC  = 4'b0010,
        CAG_ST_OPND = 4'b0100,
        CAG_ST_TBL  = 4'b1000
    } cag_state_t;

    // ======================================================================
    // whole state of the top module
    typedef struct packed {
        cag_state_t  st;
        cag_op_t     op;
        logic [15:0] pc;
        logic [15:0] ea;
        logic        ea_valid;
        cag_area_t   area;
        logic        addr_err;
        logic        done;
        logic        busy;
        logic        mem_rd;
        logic [15:0] mem_addr;
        logic [15:0] tmp;
        logic [2:0]  code;
        logic [1:0]  bank;
        logic [15:0] reg_data;
        logic        rf_we;
        logic [1:0]  rf_be;
        logic [3:0]  rf_waddr;
        logic [15:0] rf_wdata;
        logic [3:0]  rf_raddr;
    } cag_core_t;

endpackage : cag_pkg

// file: src/cag_regfile.sv
`timescale 1ns/1ps
`include "cag_regs.svh"

// four banks of four pairs, low byte first
module cag_regfile #(
    parameter int PAIRS = 16
) (
    input  wire logic ref_clk_i,
    input  wire logic sys_rst_i,
    cag_rf_if.mem     rf
);
    logic [15:0] mem_reg [PAIRS];
    logic [15:0] rd_reg;

    assign rf.rd_data = rd_reg;

    // ======================================================================
    // storage, byte lanes written separately
    genvar g;
    generate
        for (g = 0; g < PAIRS; g++) begin : g_pair
            always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    mem_reg[g] <= `CAG_REG_RESET;
                end else if (rf.wr_en && rf.wr_addr == 4'(g)) begin
                    if (rf.wr_be[0]) begin
                        mem_reg[g][7:0] <= rf.wr_data[7:0];
                    end
                    if (rf.wr_be[1]) begin
                        mem_reg[g][15:8] <= rf.wr_data[15:8];
                    end
                end
            end
        end
    endgenerate

    // ======================================================================
    // registered read port
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rd_reg <= `CAG_REG_RESET;
        end else begin
            rd_reg <= mem_reg[rf.rd_addr];
        end
    end
endmodule : cag_regfile

// file: src/cag_regs.svh
`ifndef CAG_REGS_SVH
`define CAG_REGS_SVH

// ==========================================================================
// reset values
`define CAG_PC_RESET        16'h0000
`define CAG_REG_RESET       16'h0000

// ==========================================================================
// fixed address areas
`define CAG_FIXED_PAGE      5'h01
`define CAG_TABLE_BASE      16'h0040
`define CAG_SADDR_PAGE      7'h7F
`define CAG_SADDR_WRAP      8'h20
`define CAG_SFR_PAGE        8'hFF
`define CAG_SFR_GAP_LO      8'hD0
`define CAG_SFR_GAP_HI      8'hDF

// ==========================================================================
// register field positions
`define CAG_ACC_PAIR        2'h0
`define CAG_BYTE_SEL_BIT    0
`define CAG_VEC_IDX_LSB     1
`define CAG_VEC_IDX_MSB     5

`endif

// file: src/cag_rf_if.sv
`timescale 1ns/1ps

interface cag_rf_if;
    logic [3:0]  rd_addr;
    logic [15:0] rd_data;
    logic        wr_en;
    logic [1:0]  wr_be;
    logic [3:0]  wr_addr;
    logic [15:0] wr_data;

    modport core (
        output rd_addr,
        input  rd_data,
        output wr_en,
        output wr_be,
        output wr_addr,
        output wr_data
    );

    modport mem (
        input  rd_addr,
        output rd_data,
        input  wr_en,
        input  wr_be,
        input  wr_addr,
        input  wr_data
    );
endinterface : cag_rf_if

// file: src/cag_top.sv
`timescale 1ns/1ps
`include "cag_regs.svh"

// Contract
// - pc steps by one per fetched byte
// - relative target: next pc plus signed byte
// - short jump and conditional branches are relative
// - long jump and call load 16-bit immediate
// - fixed-area call lands in 0800H to 0FFFH
// - vectored call loads table entry 40H-7FH
// - register jump loads accumulator pair into pc
// - multiply accumulator byte by register into pair
// - divide uses accumulator pair as dividend, quotient
// - adjust and digit rotate use accumulator byte
// - bank flags plus opcode code select register
// - register codes map to fixed named storage
// - direct addressing uses 16-bit immediate unchanged
// - short direct reaches FE20H to FF1FH window
// - bit 8 set only for field 00H-1FH
// - word short direct operands need even address
// - window splits into fast RAM and SFRs
// - sfr offset forms FFxxH, gap FFD0H-FFDFH
module cag_top (
    input  wire logic              ref_clk_i,
    input  wire logic              sys_rst_i,
    input  wire logic              fetch_i,
    input  wire logic              op_valid_i,
    input  wire cag_pkg::cag_op_t  op_i,
    input  wire logic [7:0]        relative_displacement_i,
    input  wire logic [15:0]       absolute_address_operand_i,
    input  wire logic [7:0]        opcode_i,
    input  wire logic [2:0]        byte_register_code_i,
    input  wire logic [1:0]        pair_register_code_i,
    input  wire logic              bank_select_low_i,
    input  wire logic              bank_select_high_i,
    input  wire logic              mem_ack_i,
    input  wire logic [15:0]       mem_rdata_i,
    input  wire logic              host_wr_i,
    input  wire logic [3:0]        host_wr_pair_i,
    input  wire logic [1:0]        host_wr_be_i,
    input  wire logic [15:0]       host_wr_data_i,
    output logic [15:0]            pc_o,
    output logic [15:0]            ea_o,
    output logic                   ea_valid_o,
    output cag_pkg::cag_area_t     area_o,
    output logic                   addr_err_o,
    output logic [15:0]            reg_data_o,
    output logic                   done_o,
    output logic                   busy_o,
    output logic                   mem_rd_o,
    output logic [15:0]            mem_addr_o
);
    cag_pkg::cag_core_t s_reg;
    cag_pkg::cag_core_t s_next;
    cag_rf_if           rf ();

    logic [1:0]  bank_w;
    logic [7:0]  acc_w;
    logic [7:0]  opnd_w;
    logic [15:0] prod_w;
    logic [15:0] quot_w;
    logic [7:0]  rem_w;
    logic [15:0] disp_w;
    logic [7:0]  sad_w;
    logic [15:0] sad_ea_w;

    cag_regfile #(
        .PAIRS (16)
    ) u_regfile (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .rf        (rf.mem)
    );

    // ======================================================================
    // register file hookup
    assign rf.rd_addr = s_next.rf_raddr;
    assign rf.wr_en   = s_reg.rf_we;
    assign rf.wr_be   = s_reg.rf_be;
    assign rf.wr_addr = s_reg.rf_waddr;
    assign rf.wr_data = s_reg.rf_wdata;

    // ======================================================================
    // datapath helpers
    assign bank_w = {bank_select_high_i, bank_select_low_i};
    assign acc_w  = s_reg.tmp[15:8];
    assign opnd_w = s_reg.code[`CAG_BYTE_SEL_BIT] ?
                    rf.rd_data[15:8] : rf.rd_data[7:0];
    assign prod_w = acc_w * opnd_w;
    assign quot_w = (opnd_w == 8'h00) ? 16'hFFFF :
                    s_reg.tmp / {8'h00, opnd_w};
    assign rem_w  = (opnd_w == 8'h00) ? s_reg.tmp[7:0] :
                    8'(s_reg.tmp % {8'h00, opnd_w});
    assign disp_w = {{8{relative_displacement_i[7]}},
                     relative_displacement_i};
    assign sad_w  = absolute_address_operand_i[7:0];
    // field 20H-FFH maps to FE20H-FEFFH, 00H-1FH to FF00H-FF1FH
    assign sad_ea_w = {`CAG_SADDR_PAGE,
                       (sad_w < `CAG_SADDR_WRAP),
                       sad_w};

    // ======================================================================
    // next state
    always_comb begin
        s_next          = s_reg;
        s_next.done     = 1'b0;
        s_next.rf_we    = 1'b0;
        s_next.rf_be    = 2'b00;
        s_next.ea_valid = 1'b0;
        unique case (s_reg.st)
            cag_pkg::CAG_ST_IDLE: begin
                if (op_valid_i) begin
                    s_next.op   = op_i;
                    s_next.bank = bank_w;
                    s_next.code = byte_register_code_i;
                    s_next.addr_err = 1'b0;
                    unique case (op_i)
                        cag_pkg::CAG_OP_REL: begin
                            // pc already points past the instruction
                            s_next.pc   = 16'(s_reg.pc + disp_w);
                            s_next.done = 1'b1;
                        end
                        cag_pkg::CAG_OP_JMP16: begin
                            s_next.pc   = absolute_address_operand_i;
                            s_next.done = 1'b1;
                        end
                        cag_pkg::CAG_OP_FIXED: begin
                            s_next.pc   = {`CAG_FIXED_PAGE,
                                absolute_address_operand_i[10:0]};
                            s_next.done = 1'b1;
                        end
                        cag_pkg::CAG_OP_VEC: begin
                            s_next.mem_addr = `CAG_TABLE_BASE |
                                {10'h000,
                                 opcode_i[`CAG_VEC_IDX_MSB:`CAG_VEC_IDX_LSB],
                                 1'b0};
                            s_next.mem_rd = 1'b1;
                            s_next.busy   = 1'b1;
                            s_next.st     = cag_pkg::CAG_ST_TBL;
                        end
                        cag_pkg::CAG_OP_REGJ,
                        cag_pkg::CAG_OP_MUL,
                        cag_pkg::CAG_OP_DIV,
                        cag_pkg::CAG_OP_IMPL: begin
                            // implied operand: accumulator pair
                            s_next.rf_raddr = {bank_w, `CAG_ACC_PAIR};
                            s_next.busy = 1'b1;
                            s_next.st   = cag_pkg::CAG_ST_ACC;
                        end
                        cag_pkg::CAG_OP_REGB: begin
                            s_next.rf_raddr = {bank_w,
                                byte_register_code_i[2:1]};
                            s_next.busy = 1'b1;
                            s_next.st   = cag_pkg::CAG_ST_OPND;
                        end
                        cag_pkg::CAG_OP_REGW: begin
                            s_next.rf_raddr = {bank_w,
                                pair_register_code_i};
                            s_next.busy = 1'b1;
                            s_next.st   = cag_pkg::CAG_ST_OPND;
                        end
                        cag_pkg::CAG_OP_DIR: begin
                            s_next.ea       = absolute_address_operand_i;
                            s_next.area     = cag_pkg::CAG_AREA_MEM;
                            s_next.ea_valid = 1'b1;
                            s_next.done     = 1'b1;
                        end
                        cag_pkg::CAG_OP_SADDR,
                        cag_pkg::CAG_OP_SADDRP: begin
                            s_next.ea = sad_ea_w;
                            s_next.area = sad_ea_w[8] ?
                                cag_pkg::CAG_AREA_SFR :
                                cag_pkg::CAG_AREA_RAM;
                            if (op_i == cag_pkg::CAG_OP_SADDRP) begin
                                // word access forced even, odd flagged
                                s_next.ea[0]    = 1'b0;
                                s_next.addr_err = sad_w[0];
                            end
                            s_next.ea_valid = 1'b1;
                            s_next.done     = 1'b1;
                        end
                        cag_pkg::CAG_OP_SFR,
                        cag_pkg::CAG_OP_SFRP: begin
                            s_next.ea = {`CAG_SFR_PAGE, sad_w};
                            s_next.area = cag_pkg::CAG_AREA_SFR;
                            s_next.addr_err =
                                (sad_w >= `CAG_SFR_GAP_LO &&
                                 sad_w <= `CAG_SFR_GAP_HI) ||
                                (op_i == cag_pkg::CAG_OP_SFRP &&
                                 sad_w[0]);
                            if (op_i == cag_pkg::CAG_OP_SFRP) begin
                                s_next.ea[0] = 1'b0;
                            end
                            s_next.ea_valid = 1'b1;
                            s_next.done     = 1'b1;
                        end
                        default: begin
                            s_next.addr_err = 1'b1;
                            s_next.done     = 1'b1;
                        end
                    endcase
                end else if (host_wr_i) begin
                    s_next.rf_we    = 1'b1;
                    s_next.rf_be    = host_wr_be_i;
                    s_next.rf_waddr = host_wr_pair_i;
                    s_next.rf_wdata = host_wr_data_i;
                end else if (fetch_i) begin
                    s_next.pc = 16'(s_reg.pc + 16'h0001);
                end
            end
            cag_pkg::CAG_ST_ACC: begin
                s_next.tmp = rf.rd_data;
                unique case (s_reg.op)
                    cag_pkg::CAG_OP_REGJ: begin
                        s_next.pc   = rf.rd_data;
                        s_next.busy = 1'b0;
                        s_next.done = 1'b1;
                        s_next.st   = cag_pkg::CAG_ST_IDLE;
                    end
                    cag_pkg::CAG_OP_IMPL: begin
                        s_next.reg_data = {8'h00, rf.rd_data[15:8]};
                        s_next.busy = 1'b0;
                        s_next.done = 1'b1;
                        s_next.st   = cag_pkg::CAG_ST_IDLE;
                    end
                    default: begin
                        s_next.rf_raddr = {s_reg.bank, s_reg.code[2:1]};
                        s_next.st       = cag_pkg::CAG_ST_OPND;
                    end
                endcase
            end
            cag_pkg::CAG_ST_OPND: begin
                s_next.busy     = 1'b0;
                s_next.done     = 1'b1;
                s_next.st       = cag_pkg::CAG_ST_IDLE;
                s_next.rf_waddr = {s_reg.bank, `CAG_ACC_PAIR};
                s_next.rf_be    = 2'b11;
                unique case (s_reg.op)
                    cag_pkg::CAG_OP_MUL: begin
                        s_next.rf_we    = 1'b1;
                        s_next.rf_wdata = prod_w;
                        s_next.reg_data = prod_w;
                    end
                    cag_pkg::CAG_OP_DIV: begin
                        s_next.rf_we    = 1'b1;
                        s_next.rf_wdata = quot_w;
                        s_next.reg_data = {8'h00, rem_w};
                    end
                    cag_pkg::CAG_OP_REGB: begin
                        s_next.rf_be    = 2'b00;
                        s_next.reg_data = {8'h00, opnd_w};
                    end
                    default: begin
                        s_next.rf_be    = 2'b00;
                        s_next.reg_data = rf.rd_data;
                    end
                endcase
            end
            cag_pkg::CAG_ST_TBL: begin
                if (mem_ack_i) begin
                    s_next.pc     = mem_rdata_i;
                    s_next.mem_rd = 1'b0;
                    s_next.busy   = 1'b0;
                    s_next.done   = 1'b1;
                    s_next.st     = cag_pkg::CAG_ST_IDLE;
                end
            end
            default: begin
                s_next.st     = cag_pkg::CAG_ST_IDLE;
                s_next.busy   = 1'b0;
                s_next.mem_rd = 1'b0;
            end
        endcase
    end

    // ======================================================================
    // state register
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_reg          <= '0;
            s_reg.st       <= cag_pkg::CAG_ST_IDLE;
            s_reg.op       <= cag_pkg::CAG_OP_REL;
            s_reg.area     <= cag_pkg::CAG_AREA_NONE;
            s_reg.pc       <= `CAG_PC_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ======================================================================
    // outputs
    assign pc_o       = s_reg.pc;
    assign ea_o       = s_reg.ea;
    assign ea_valid_o = s_reg.ea_valid;
    assign area_o     = s_reg.area;
    assign addr_err_o = s_reg.addr_err;
    assign reg_data_o = s_reg.reg_data;
    assign done_o     = s_reg.done;
    assign busy_o     = s_reg.busy;
    assign mem_rd_o   = s_reg.mem_rd;
    assign mem_addr_o = s_reg.mem_addr;
endmodule : cag_top

// file: tb/cag_mem_model.sv
`timescale 1ns/1ps

// ==========================================================================
// vector table, prompt or five-cycle answer
module cag_mem_model (
    input  wire logic        ref_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        slow_i,
    input  wire logic        mem_rd_i,
    input  wire logic [15:0] mem_addr_i,
    output logic             mem_ack_o,
    output logic [15:0]      mem_rdata_o
);
    logic [2:0] wait_reg;

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wait_reg <= 3'h0;
            mem_ack_o <= 1'b0;
            mem_rdata_o <= 16'h0000;
        end else if (mem_rd_i && !mem_ack_o &&
                     wait_reg == (slow_i ? 3'h4 : 3'h0)) begin
            mem_ack_o <= 1'b1;
            mem_rdata_o <= {mem_addr_i[7:0] ^ 8'hA5, mem_addr_i[7:0]};
        end else begin
            wait_reg <= (mem_rd_i && !mem_ack_o) ? wait_reg + 3'h1 : 3'h0;
            mem_ack_o <= 1'b0;
            // stale data inverts every cycle
            mem_rdata_o <= ~mem_rdata_o;
        end
    end
endmodule : cag_mem_model

// file: tb/cag_top_asserts.sv
`timescale 1ns/1ps

// ==========================================================================
// port checks
module cag_top_asserts (
    input wire logic             ref_clk_i,
    input wire logic             sys_rst_i,
    input wire logic             fetch_i,
    input wire logic             op_valid_i,
    input wire cag_pkg::cag_op_t op_i,
    input wire logic [7:0]       relative_displacement_i,
    input wire logic [15:0]      absolute_address_operand_i,
    input wire logic [7:0]       opcode_i,
    input wire logic             host_wr_i,
    input wire logic             mem_ack_i,
    input wire logic [15:0]      mem_rdata_i,
    input wire logic [15:0]      pc_o,
    input wire logic [15:0]      ea_o,
    input wire logic             ea_valid_o,
    input wire cag_pkg::cag_area_t area_o,
    input wire logic             addr_err_o,
    input wire logic             done_o,
    input wire logic             busy_o,
    input wire logic             mem_rd_o,
    input wire logic [15:0]      mem_addr_o
);
    logic        go;
    logic [7:0]  fld;
    logic [15:0] sext;
    logic [15:0] sd_ea;
    logic [15:0] vec_addr;

    assign go = op_valid_i && !busy_o;
    assign fld = absolute_address_operand_i[7:0];
    assign sext = {{8{relative_displacement_i[7]}}, relative_displacement_i};
    assign sd_ea = {7'h7F, fld < 8'h20, fld};
    assign vec_addr = 16'h0040 + {10'h000, opcode_i[5:1], 1'b0};

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    chk_fetch_step:
    assert property (fetch_i && !busy_o && !op_valid_i && !host_wr_i
        |=> pc_o == $past(pc_o) + 16'h0001) else $error("pc step");
    chk_rel_target:
    assert property (go && op_i == cag_pkg::CAG_OP_REL
        |=> pc_o == $past(pc_o) + $past(sext)) else $error("rel target");
    chk_long_jump:
    assert property (go && op_i == cag_pkg::CAG_OP_JMP16 |=> done_o &&
        pc_o == $past(absolute_address_operand_i)) else $error("jump wrong");
    chk_fixed_area:
    assert property (go && op_i == cag_pkg::CAG_OP_FIXED
        |=> pc_o[15:11] == 5'h01) else $error("fixed area");
    chk_vec_read:
    assert property (go && op_i == cag_pkg::CAG_OP_VEC |=> mem_rd_o && busy_o
        && mem_addr_o == $past(vec_addr)) else $error("table addr");
    chk_vec_load:
    assert property (mem_rd_o && mem_ack_i |=> done_o && !mem_rd_o &&
        pc_o == $past(mem_rdata_i)) else $error("table entry");
    chk_direct_ea:
    assert property (go && op_i == cag_pkg::CAG_OP_DIR |=> ea_valid_o &&
        ea_o == $past(absolute_address_operand_i)) else $error("direct ea");
    chk_short_ea:
    assert property (go && op_i == cag_pkg::CAG_OP_SADDR
        |=> ea_o == $past(sd_ea)) else $error("short ea");
    chk_short_area:
    assert property (go && op_i == cag_pkg::CAG_OP_SADDR |=> area_o ==
        ($past(fld) < 8'h20 ? cag_pkg::CAG_AREA_SFR : cag_pkg::CAG_AREA_RAM))
        else $error("short area");
    chk_odd_word:
    assert property (go && op_i == cag_pkg::CAG_OP_SADDRP && fld[0]
        |=> addr_err_o && !ea_o[0]) else $error("odd word");
    chk_sfr_page:
    assert property (go && op_i == cag_pkg::CAG_OP_SFR
        |=> ea_o == {8'hFF, $past(fld)}) else $error("sfr addr");
    chk_mul_time:
    assert property (go && op_i == cag_pkg::CAG_OP_MUL
        |=> busy_o [*2] ##1 done_o) else $error("mul timing");

    cover property (go && op_i == cag_pkg::CAG_OP_VEC);
    cover property (mem_rd_o && mem_ack_i);
    cover property (addr_err_o);
endmodule : cag_top_asserts

bind cag_top cag_top_asserts i_cag_top_asserts (.*);

// file: tb/cag_top_tb_top.sv
`timescale 1ns/1ps

`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin \
    failures++; $display("mismatch at %0t: got %h expected %h", \
    $time, got, exp); end end

module cag_top_tb_top;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic fetch_i = 1'b0;
    logic op_valid_i = 1'b0;
    cag_pkg::cag_op_t op_i = cag_pkg::CAG_OP_REL;
    logic [15:0] a16 = 16'h0000;
    logic [1:0] bank = 2'h0;
    logic host_wr_i = 1'b0;
    logic [3:0] wr_idx = 4'h0;
    logic [15:0] wr_data = 16'h0000;
    logic slow = 1'b0;
    logic mem_ack;
    logic [15:0] mem_rdata, pc_o, ea_o, reg_data_o, mem_addr_o;
    logic ea_valid_o, addr_err_o, done_o, busy_o, mem_rd_o;
    cag_pkg::cag_area_t area_o;
    int failures = 0;
    int samples_checked = 0;
    logic [7:0] fields [4] = '{8'h20, 8'hFF, 8'h00, 8'h1F};

    always #10 ref_clk_i = ~ref_clk_i;

    cag_top i_cag_top (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .fetch_i(fetch_i),
        .op_valid_i(op_valid_i), .op_i(op_i),
        .relative_displacement_i(a16[7:0]),
        .absolute_address_operand_i(a16), .opcode_i(a16[7:0]),
        .byte_register_code_i(a16[2:0]), .pair_register_code_i(a16[1:0]),
        .bank_select_low_i(bank[0]), .bank_select_high_i(bank[1]),
        .mem_ack_i(mem_ack), .mem_rdata_i(mem_rdata),
        .host_wr_i(host_wr_i), .host_wr_pair_i(wr_idx),
        .host_wr_be_i(2'h3), .host_wr_data_i(wr_data), .pc_o(pc_o),
        .ea_o(ea_o), .ea_valid_o(ea_valid_o), .area_o(area_o),
        .addr_err_o(addr_err_o), .reg_data_o(reg_data_o), .done_o(done_o),
        .busy_o(busy_o), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o)
    );

    cag_mem_model i_cag_mem_model (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .slow_i(slow),
        .mem_rd_i(mem_rd_o), .mem_addr_i(mem_addr_o), .mem_ack_o(mem_ack),
        .mem_rdata_o(mem_rdata)
    );

    // ======================================================================
    // drivers
    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic issue(input cag_pkg::cag_op_t op, input logic [15:0] a);
        int n;
        @(posedge ref_clk_i);
        op_valid_i <= 1'b1;
        op_i <= op;
        a16 <= a;
        @(posedge ref_clk_i);
        op_valid_i <= 1'b0;
        #1;
        n = 0;
        while (done_o !== 1'b1 && n < 20) begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        if (done_o !== 1'b1) begin
            failures++;
            tally_and_finish();
        end
    endtask : issue

    task automatic host_write(input logic [3:0] idx, input logic [15:0] d);
        @(posedge ref_clk_i);
        host_wr_i <= 1'b1;
        wr_idx <= idx;
        wr_data <= d;
        @(posedge ref_clk_i);
        host_wr_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask : host_write

    // ======================================================================
    // scenarios
    task automatic t_branch();
        issue(cag_pkg::CAG_OP_JMP16, 16'h1234);
        `CHK(pc_o, 16'h1234)
        @(posedge ref_clk_i);
        fetch_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        fetch_i <= 1'b0;
        #1;
        `CHK(pc_o, 16'h1237)
        issue(cag_pkg::CAG_OP_JMP16, 16'hFFF0);
        issue(cag_pkg::CAG_OP_REL, 16'h007F);
        `CHK(pc_o, 16'h006F)
        issue(cag_pkg::CAG_OP_REL, 16'h0080);
        `CHK(pc_o, 16'hFFEF)
        issue(cag_pkg::CAG_OP_FIXED, 16'hFFFF);
        `CHK(pc_o, 16'h0FFF)
        issue(cag_pkg::CAG_OP_FIXED, 16'h0000);
        `CHK(pc_o, 16'h0800)
        $display("t_branch done");
    endtask : t_branch

    task automatic t_vector();
        issue(cag_pkg::CAG_OP_VEC, 16'h003E);
        `CHK(pc_o, {8'h7E ^ 8'hA5, 8'h7E})
        slow <= 1'b1;
        issue(cag_pkg::CAG_OP_VEC, 16'h0000);
        `CHK(pc_o, {8'h40 ^ 8'hA5, 8'h40})
        $display("t_vector done");
    endtask : t_vector

    task automatic t_registers();
        bank <= 2'h2;
        host_write(4'h9, 16'hB1C1);
        issue(cag_pkg::CAG_OP_REGB, 16'h0003);
        `CHK(reg_data_o[7:0], 8'hB1)
        issue(cag_pkg::CAG_OP_REGB, 16'h0002);
        `CHK(reg_data_o[7:0], 8'hC1)
        issue(cag_pkg::CAG_OP_REGW, 16'h0001);
        `CHK(reg_data_o, 16'hB1C1)
        bank <= 2'h0;
        issue(cag_pkg::CAG_OP_REGW, 16'h0001);
        `CHK(reg_data_o, 16'h0000)
        $display("t_registers done");
    endtask : t_registers

    task automatic t_arith();
        host_write(4'h0, 16'hC805);
        issue(cag_pkg::CAG_OP_MUL, 16'h0000);
        `CHK(reg_data_o, 16'h03E8)
        issue(cag_pkg::CAG_OP_REGW, 16'h0000);
        `CHK(reg_data_o, 16'h03E8)
        issue(cag_pkg::CAG_OP_IMPL, 16'h0000);
        `CHK(reg_data_o[7:0], 8'h03)
        host_write(4'h1, 16'h0007);
        issue(cag_pkg::CAG_OP_DIV, 16'h0002);
        `CHK(reg_data_o[7:0], 8'h06)
        issue(cag_pkg::CAG_OP_REGW, 16'h0000);
        `CHK(reg_data_o, 16'h008E)
        issue(cag_pkg::CAG_OP_REGJ, 16'h0000);
        `CHK(pc_o, 16'h008E)
        $display("t_arith done");
    endtask : t_arith

    task automatic t_operand();
        issue(cag_pkg::CAG_OP_DIR, 16'hFE00);
        `CHK(ea_o, 16'hFE00)
        foreach (fields[i]) begin
            issue(cag_pkg::CAG_OP_SADDR, {8'h00, fields[i]});
            `CHK(ea_o, {7'h7F, fields[i] < 8'h20, fields[i]})
            `CHK(area_o, 2'(1 + (fields[i] < 8'h20)))
        end
        `CHK(ea_o, 16'hFF1F)
        issue(cag_pkg::CAG_OP_SADDRP, 16'h0031);
        `CHK({addr_err_o, ea_o}, {1'b1, 16'hFE30})
        issue(cag_pkg::CAG_OP_SADDRP, 16'h0030);
        `CHK(addr_err_o, 1'b0)
        issue(cag_pkg::CAG_OP_SFR, 16'h0020);
        `CHK(ea_o, 16'hFF20)
        issue(cag_pkg::CAG_OP_SFR, 16'h00D5);
        `CHK(addr_err_o, 1'b1)
        $display("t_operand done");
    endtask : t_operand

    initial begin
        repeat (6) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        t_branch();
        t_vector();
        t_registers();
        t_arith();
        t_operand();
        tally_and_finish();
    end
endmodule : cag_top_tb_top
